/* dv/qdcc_assertions.sv */
/*
 * Checker of the qdcc_top ports, bound to every instance of it.
 * Assumes one clock domain with the synchronous srst.
 */
module qdcc_chk #(
    parameter CODE_WIDTH = 14,
    parameter CHANNELS = 4
) (
    // system
    input wire clock,
    input wire srst,
    // serial port
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    input wire sdo,
    input wire sdo_oe,
    // pins
    input wire hw_latch_update_pin_n,
    input wire [1:0] gpio_in,
    input wire [1:0] gpio_out,
    input wire [1:0] gpio_oe,
    // analog side
    input wire [CHANNELS*CODE_WIDTH-1:0] dac_codes,
    input wire [CHANNELS-1:0] chan_sleep,
    input wire [CHANNELS-1:0] chan_gain_x4,
    input wire group_a_sleep,
    input wire group_b_sleep
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // ages since the last frame end and the last low update pin
    // ------------------------------------------------------------
    // saturating, so a long idle spell never wraps into a false cause
    logic [3:0] cs_age = 4'hF;
    logic [3:0] pin_age = 4'hF;
    always @(posedge clock) begin
        cs_age <= $rose(cs_n) ? 4'h0 : cs_age + {3'h0, cs_age != 4'hF};
        pin_age <= !hw_latch_update_pin_n ? 4'h0 :
            pin_age + {3'h0, pin_age != 4'hF};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    a_reset_state: assert property (
        $fell(srst) |-> dac_codes == '0 && chan_gain_x4 == 4'hF &&
        gpio_oe == 2'h0 && !group_a_sleep && !group_b_sleep)
        else $error("state after reset wrong");
    a_group_a_map: assert property (
        chan_sleep[1:0] == {2{group_a_sleep}}) else $error("group a map");
    a_group_b_map: assert property (
        chan_sleep[3:2] == {2{group_b_sleep}}) else $error("group b map");
    a_gpio_drive_low: assert property (
        gpio_out == 2'h0) else $error("gpio drives high");
    a_latch_cause: assert property (
        $changed(dac_codes) |-> cs_age <= 4'h8 || pin_age <= 4'h5)
        else $error("latch changed without cause");
    a_control_cause: assert property (
        $changed({group_a_sleep, group_b_sleep, chan_gain_x4, gpio_oe})
        |-> cs_age <= 4'h8) else $error("control changed without frame");
    a_sdo_released: assert property (
        cs_n [*4] |-> !sdo_oe) else $error("sdo driven while deselected");
    a_sdo_driven: assert property (
        (!cs_n) [*5] |-> sdo_oe) else $error("sdo not driven in frame");
    cover property ($rose(group_a_sleep));
    cover property ($changed(dac_codes));
    cover property ($rose(gpio_oe[1]));
endmodule

bind qdcc_top qdcc_chk #(.CODE_WIDTH(CODE_WIDTH), .CHANNELS(CHANNELS))
    chk (
        .clock(clock),
        .srst(srst),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .hw_latch_update_pin_n(hw_latch_update_pin_n),
        .gpio_in(gpio_in),
        .gpio_out(gpio_out),
        .gpio_oe(gpio_oe),
        .dac_codes(dac_codes),
        .chan_sleep(chan_sleep),
        .chan_gain_x4(chan_gain_x4),
        .group_a_sleep(group_a_sleep),
        .group_b_sleep(group_b_sleep)
    );

/* dv/qdcc_host.sv */
/*
 * Host controller model issuing 24-bit serial frames, msb first.
 * Assumes the 10 MHz clock; lines change on its falling edges.
 */
module qdcc_host (
    // system
    input wire clock,
    // serial port
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire sdo,
    input wire sdo_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // five clocks, above the four the slave needs to see a level
    task automatic half;
        repeat (5) @(negedge clock);
    endtask
    // serial clock stands high between frames
    task automatic xfer(input logic [23:0] w, output logic [23:0] r);
        @(negedge clock);
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = w[i];
            half();
            r[i] = sdo_oe ? sdo : 1'b1;
            sclk = 1'b0;
            half();
            sclk = 1'b1;
        end
        half();
        cs_n = 1'b1;
        sdi = ~w[0];
        repeat (10) @(negedge clock);
    endtask
endmodule

/* dv/quad_dac_command_control_tb.sv */
/*
 * Testbench of qdcc_top: the host model sends frames, the bench checks
 * read-back words and the analog-side ports.
 * Assumes the design, checker and host model are compiled before it.
 */
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: %h not %h", $time, g, e); end end

module quad_dac_command_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic hw_latch_update_pin_n = 1'b1;
    logic [1:0] ext = 2'h3;
    wire sclk, cs_n, sdi, sdo, sdo_oe, group_a_sleep, group_b_sleep;
    wire [1:0] gpio_in, gpio_out, gpio_oe;
    wire [55:0] dac_codes;
    wire [3:0] chan_sleep, chan_gain_x4;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [15:0] d;
    always #50 clock = ~clock;
    // open-drain wire: low while driven, else the outside level
    assign gpio_in = ext & ~gpio_oe;
    qdcc_top dut (
        .clock(clock),
        .srst(srst),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .hw_latch_update_pin_n(hw_latch_update_pin_n),
        .gpio_in(gpio_in),
        .gpio_out(gpio_out),
        .gpio_oe(gpio_oe),
        .dac_codes(dac_codes),
        .chan_sleep(chan_sleep),
        .chan_gain_x4(chan_gain_x4),
        .group_a_sleep(group_a_sleep),
        .group_b_sleep(group_b_sleep)
    );
    qdcc_host host (
        .clock(clock),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe)
    );
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        logic [23:0] r;
        host.xfer({4'h0, a, v}, r);
    endtask
    // the answer comes out during the frame after the command
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        logic [23:0] r;
        host.xfer({4'h8, a, 16'h0000}, r);
        host.xfer({4'h8, a, 16'h0000}, r);
        `CHK(r[23:16], {4'h0, a})
        v = r[15:0];
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clock);
        srst = 1'b0;
        repeat (3) @(negedge clock);
        rd(4'h0, d);
        `CHK(d, 16'h033C)
        `CHK({chan_gain_x4, chan_sleep, gpio_oe, dac_codes}, {8'hF0, 58'h0})
        wr(4'h4, 16'hABCF);
        wr(4'h5, 16'h1237);
        rd(4'h4, d);
        `CHK(d, 16'hABCC)
        `CHK(dac_codes, 56'h0)
        wr(4'h0, 16'h833C);
        rd(4'h4, d);
        `CHK(d, 16'h0000)
        wr(4'h0, 16'hC33C);
        `CHK(dac_codes, {28'h0, 14'h048D, 14'h2AF3})
        rd(4'h5, d);
        `CHK(d, 16'h1234)
        rd(4'h0, d);
        `CHK(d, 16'h833C)
        wr(4'h6, 16'h4444);
        wr(4'h0, 16'h033C);
        `CHK(dac_codes[41:28], 14'h0)
        hw_latch_update_pin_n = 1'b0;
        repeat (5) @(negedge clock);
        `CHK(dac_codes[41:28], 14'h1111)
        wr(4'h0, 16'h433C);
        rd(4'h0, d);
        `CHK(d, 16'h033C)
        hw_latch_update_pin_n = 1'b1;
        wr(4'h0, 16'h133C);
        `CHK({group_a_sleep, group_b_sleep, chan_sleep}, 6'h23)
        rd(4'h0, d);
        `CHK(d, 16'h133C)
        wr(4'h0, 16'h0F3C);
        `CHK({group_a_sleep, group_b_sleep, chan_sleep}, 6'h1C)
        rd(4'h0, d);
        `CHK(d, 16'h0B3C)
        wr(4'h0, 16'h003C);
        `CHK(gpio_oe, 2'h3)
        rd(4'h0, d);
        `CHK(d, 16'h003C)
        wr(4'h0, 16'h023C);
        `CHK(gpio_oe, 2'h1)
        ext = 2'h1;
        rd(4'h0, d);
        `CHK(d, 16'h003C)
        ext = 2'h3;
        rd(4'h0, d);
        `CHK(d, 16'h023C)
        wr(4'h7, 16'hFFFF);
        wr(4'h0, 16'h433C);
        `CHK(dac_codes, {14'h3FFF, 14'h1111, 14'h048D, 14'h2AF3})
        wr(4'h0, 16'h2000);
        `CHK({chan_gain_x4, chan_sleep, gpio_oe, dac_codes}, {8'hF0, 58'h0})
        rd(4'h0, d);
        `CHK(d, 16'h033C)
        rd(4'h1, d);
        `CHK(d, 16'h0000)
        rd(4'h9, d);
        `CHK(d, 16'h0000)
        tally_and_finish();
    end
endmodule

/* rtl/qdcc_chan.v */
/*
 * One DAC channel: input data register, DAC latch and the written-since-
 * last-update mark that decides whether an update reloads the latch.
 * Assumes the update strobe and write strobe come from the same clock.
 */
module qdcc_chan #(
    parameter WIDTH = 14
) (
    // system
    input wire clock,
    input wire rst,
    // control
    input wire wr,
    input wire [WIDTH-1:0] wr_code,
    input wire update,
    // state
    output reg [WIDTH-1:0] input_code,
    output reg [WIDTH-1:0] latch_code
);

reg dirty;

// ----------------------------------------------------------------
// input register and latch
// ----------------------------------------------------------------
// a write in the update cycle keeps its mark: set wins over clear
always @(posedge clock) begin
    if (rst) begin
        input_code <= {WIDTH{1'b0}};
        latch_code <= {WIDTH{1'b0}};
        dirty <= 1'b0;
    end else begin
        if (update && dirty) begin
            latch_code <= input_code;
        end
        if (wr) begin
            input_code <= wr_code;
            dirty <= 1'b1;
        end else if (update) begin
            dirty <= 1'b0;
        end
    end
end

endmodule

/* rtl/qdcc_regs.vh */
/*
 * Constants of the quad DAC command control block: register addresses,
 * command bit positions, reset value and serial frame layout.
 * Assumes it is included by bare name from the rtl files only.
 */
`ifndef QDCC_REGS_VH
`define QDCC_REGS_VH

// ----------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------
`define QDCC_FRAME_BITS 5'h18
`define QDCC_FRAME_RW 23
`define QDCC_FRAME_ADDR_HI 19
`define QDCC_FRAME_ADDR_LO 16

// ----------------------------------------------------------------
// register addresses (4-bit field of the frame)
// ----------------------------------------------------------------
`define QDCC_ADDR_CONTROL 4'h0
`define QDCC_ADDR_CHAN_BASE 4'h4
`define QDCC_ADDR_CHAN_LAST 4'h7

// ----------------------------------------------------------------
// control_command fields
// ----------------------------------------------------------------
`define QDCC_CMD_RESET 16'h033C
`define QDCC_BIT_READ_LATCH 15
`define QDCC_BIT_LOAD_ALL 14
`define QDCC_BIT_RESTART 13
`define QDCC_BIT_SLEEP_A 12
`define QDCC_BIT_SLEEP_B 11
`define QDCC_BIT_RSVD 10
`define QDCC_BIT_GPIO1 9
`define QDCC_BIT_GPIO0 8
`define QDCC_BIT_GAIN_HI 5
`define QDCC_BIT_GAIN_LO 2

// ----------------------------------------------------------------
// channel data field
// ----------------------------------------------------------------
`define QDCC_CODE_HI 15
`define QDCC_CODE_LO 2

`endif

/* rtl/qdcc_spi_rx.v */
/*
 * Serial slave of the quad DAC command control block: synchronises the
 * pins, collects 24-bit frames and shifts out the read-back word.
 * Assumes sclk is well below a quarter of the system clock rate.
 */
`include "qdcc_regs.vh"

module qdcc_spi_rx (
    // system
    input wire clock,
    input wire rst,
    // pins
    input wire sclk_pin,
    input wire cs_n_pin,
    input wire sdi_pin,
    output wire sdo,
    output wire sdo_oe,
    // frame side
    input wire [23:0] tx_word,
    output reg [23:0] frame_word,
    output reg frame_valid
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg sclk_m, sclk_s, sclk_d;
reg cs_m, cs_s, cs_d;
reg sdi_m, sdi_s;
reg [23:0] rx_sh;
reg [23:0] tx_sh;
reg [4:0] cnt;

wire sclk_fall = sclk_d & ~sclk_s;
wire sclk_rise = ~sclk_d & sclk_s;
wire cs_fall = cs_d & ~cs_s;
wire cs_rise = ~cs_d & cs_s;

assign sdo = tx_sh[23];
assign sdo_oe = ~cs_s;

always @(posedge clock) begin
    if (rst) begin
        // idle level of the serial clock, so no false edge after reset
        sclk_m <= 1'b1;
        sclk_s <= 1'b1;
        sclk_d <= 1'b1;
        cs_m <= 1'b1;
        cs_s <= 1'b1;
        cs_d <= 1'b1;
        sdi_m <= 1'b0;
        sdi_s <= 1'b0;
    end else begin
        sclk_m <= sclk_pin;
        sclk_s <= sclk_m;
        sclk_d <= sclk_s;
        cs_m <= cs_n_pin;
        cs_s <= cs_m;
        cs_d <= cs_s;
        sdi_m <= sdi_pin;
        sdi_s <= sdi_m;
    end
end

// ----------------------------------------------------------------
// shifting
// ----------------------------------------------------------------
// a frame of the wrong length is dropped whole, never half applied
always @(posedge clock) begin
    if (rst) begin
        rx_sh <= 24'h000000;
        tx_sh <= 24'h000000;
        cnt <= 5'h00;
        frame_word <= 24'h000000;
        frame_valid <= 1'b0;
    end else begin
        frame_valid <= 1'b0;
        if (cs_fall) begin
            cnt <= 5'h00;
            tx_sh <= tx_word;
        end else if (!cs_s) begin
            if (sclk_fall) begin
                rx_sh <= {rx_sh[22:0], sdi_s};
                if (cnt != 5'h1F) begin
                    cnt <= cnt + 5'h01;
                end
            end
            if (sclk_rise && cnt != 5'h00) begin
                tx_sh <= {tx_sh[22:0], 1'b0};
            end
        end
        if (cs_rise && cnt == `QDCC_FRAME_BITS) begin
            frame_word <= rx_sh;
            frame_valid <= 1'b1;
        end
    end
end

endmodule

/* rtl/qdcc_top.v */
/*
 * Command register control of a quad 14-bit DAC: serial register access,
 * read-back source select, load-all update, software restart, group
 * sleep and two open-drain general-purpose pins.
 * Assumes a 10 MHz clock, pins asynchronous to it, serial clock slow
 * enough to be sampled, and the pin wires resolved outside.
 */
`include "qdcc_regs.vh"

// How it works
// - reset loads control register with 033Ch
// - read-source bit picks input or latch
// - load-all copies written channels to latches
// - only channels written since update reload
// - load-all bit clears after the update
// - load-all ignored while load pin low
// - restart bit resets all but the update-pin and gpio synchronisers, reads zero
// - group A sleep powers down channels 0,1
// - group B sleep powers down channels 2,3
// - serial side keeps working during sleep
// - reserved bit ignored, reads zero
// - gpio1 bit: one releases, zero drives low
// - gpio0 bit: one releases, zero drives low
// - gpio bits read back the pin level
// - access by 24-bit frame: rw, address, data
module qdcc_top #(
    parameter CODE_WIDTH = 14,
    parameter CHANNELS = 4
) (
    // system
    input wire clock,
    input wire srst,
    // serial port
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    output wire sdo,
    output wire sdo_oe,
    // hardware update pin, active low
    input wire hw_latch_update_pin_n,
    // general-purpose open-drain pins
    input wire [1:0] gpio_in,
    output wire [1:0] gpio_out,
    output wire [1:0] gpio_oe,
    // analog side controls
    output wire [CHANNELS*CODE_WIDTH-1:0] dac_codes,
    output wire [CHANNELS-1:0] chan_sleep,
    output wire [CHANNELS-1:0] chan_gain_x4,
    output wire group_a_sleep,
    output wire group_b_sleep
);

// ----------------------------------------------------------------
// internal reset
// ----------------------------------------------------------------
// restart is a one-cycle pulse that feeds back into the same reset
// net as srst; only the update-pin and gpio synchronisers are reset by srst alone
reg restart_pending;
wire int_rst = srst | restart_pending;

// ----------------------------------------------------------------
// control_command storage
// ----------------------------------------------------------------
reg read_latch;
reg load_all_trigger;
reg sleep_a;
reg sleep_b;
reg [1:0] gpio_release;
reg [3:0] gain_x4;

// reset image of the whole register, sliced per field below
localparam [15:0] cmd_reset = `QDCC_CMD_RESET;

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg hw_latch_update_pin_m, hw_latch_update_pin_s;
reg [1:0] gpio_m, gpio_s;

always @(posedge clock) begin
    if (srst) begin
        hw_latch_update_pin_m <= 1'b1;
        hw_latch_update_pin_s <= 1'b1;
        gpio_m <= 2'h3;
        gpio_s <= 2'h3;
    end else begin
        hw_latch_update_pin_m <= hw_latch_update_pin_n;
        hw_latch_update_pin_s <= hw_latch_update_pin_m;
        gpio_m <= gpio_in;
        gpio_s <= gpio_m;
    end
end

// ----------------------------------------------------------------
// serial slave
// ----------------------------------------------------------------
wire [23:0] frame_word;
wire frame_valid;
reg [23:0] tx_word;

qdcc_spi_rx u_spi (
    .clock(clock),
    .rst(int_rst),
    .sclk_pin(sclk),
    .cs_n_pin(cs_n),
    .sdi_pin(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .tx_word(tx_word),
    .frame_word(frame_word),
    .frame_valid(frame_valid)
);

// ----------------------------------------------------------------
// frame decode
// ----------------------------------------------------------------
wire frame_read = frame_word[`QDCC_FRAME_RW];
wire [3:0] frame_addr =
    frame_word[`QDCC_FRAME_ADDR_HI:`QDCC_FRAME_ADDR_LO];
wire [15:0] frame_data = frame_word[15:0];

reg wr_control;
reg [CHANNELS-1:0] wr_chan;
reg rd_known;

always @* begin
    wr_control = 1'b0;
    wr_chan = {CHANNELS{1'b0}};
    rd_known = 1'b0;
    if (frame_addr == `QDCC_ADDR_CONTROL) begin
        wr_control = frame_valid & ~frame_read;
        rd_known = 1'b1;
    end else if (frame_addr >= `QDCC_ADDR_CHAN_BASE &&
                 frame_addr <= `QDCC_ADDR_CHAN_LAST) begin
        wr_chan[frame_addr[1:0]] = frame_valid & ~frame_read;
        rd_known = 1'b1;
    end
end

// ----------------------------------------------------------------
// latch update
// ----------------------------------------------------------------
// a pin held low updates written channels at once; a high pin needs
// the load-all pulse
wire update_all = load_all_trigger | ~hw_latch_update_pin_s;

// ----------------------------------------------------------------
// channels
// ----------------------------------------------------------------
wire [CHANNELS*CODE_WIDTH-1:0] input_codes;
wire [CODE_WIDTH-1:0] wr_code = frame_data[`QDCC_CODE_HI:`QDCC_CODE_LO];

genvar gi;
generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_chan
        qdcc_chan #(
            .WIDTH(CODE_WIDTH)
        ) u_chan (
            .clock(clock),
            .rst(int_rst),
            .wr(wr_chan[gi]),
            .wr_code(wr_code),
            .update(update_all),
            .input_code(input_codes[gi*CODE_WIDTH +: CODE_WIDTH]),
            .latch_code(dac_codes[gi*CODE_WIDTH +: CODE_WIDTH])
        );
        // the lower half of the channels forms group A
        assign chan_sleep[gi] = (gi < CHANNELS / 2) ? sleep_a : sleep_b;
    end
endgenerate

// ----------------------------------------------------------------
// control register writes
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (int_rst) begin
        read_latch <= cmd_reset[`QDCC_BIT_READ_LATCH];
        load_all_trigger <= cmd_reset[`QDCC_BIT_LOAD_ALL];
        sleep_a <= cmd_reset[`QDCC_BIT_SLEEP_A];
        sleep_b <= cmd_reset[`QDCC_BIT_SLEEP_B];
        gpio_release <= cmd_reset[`QDCC_BIT_GPIO1:`QDCC_BIT_GPIO0];
        gain_x4 <= cmd_reset[`QDCC_BIT_GAIN_HI:`QDCC_BIT_GAIN_LO];
    end else begin
        load_all_trigger <= 1'b0;
        if (wr_control) begin
            read_latch <= frame_data[`QDCC_BIT_READ_LATCH];
            // only a one starts an update, and only with the pin high
            if (frame_data[`QDCC_BIT_LOAD_ALL] && hw_latch_update_pin_s) begin
                load_all_trigger <= 1'b1;
            end
            sleep_a <= frame_data[`QDCC_BIT_SLEEP_A];
            sleep_b <= frame_data[`QDCC_BIT_SLEEP_B];
            gpio_release[1] <= frame_data[`QDCC_BIT_GPIO1];
            gpio_release[0] <= frame_data[`QDCC_BIT_GPIO0];
            gain_x4 <= frame_data[`QDCC_BIT_GAIN_HI:`QDCC_BIT_GAIN_LO];
        end
    end
end

// restart is cleared by the very reset it raises
always @(posedge clock) begin
    if (int_rst) begin
        restart_pending <= 1'b0;
    end else if (wr_control && frame_data[`QDCC_BIT_RESTART]) begin
        restart_pending <= 1'b1;
    end
end

// ----------------------------------------------------------------
// read-back
// ----------------------------------------------------------------
reg [15:0] control_command;
reg [15:0] rd_data;
reg [CODE_WIDTH-1:0] sel_code;

always @* begin
    control_command = 16'h0000;
    control_command[`QDCC_BIT_READ_LATCH] = read_latch;
    control_command[`QDCC_BIT_LOAD_ALL] = load_all_trigger;
    control_command[`QDCC_BIT_RESTART] = restart_pending;
    control_command[`QDCC_BIT_SLEEP_A] = sleep_a;
    control_command[`QDCC_BIT_SLEEP_B] = sleep_b;
    control_command[`QDCC_BIT_RSVD] = 1'b0;
    control_command[`QDCC_BIT_GPIO1] = gpio_s[1];
    control_command[`QDCC_BIT_GPIO0] = gpio_s[0];
    control_command[`QDCC_BIT_GAIN_HI:`QDCC_BIT_GAIN_LO] = gain_x4;
end

always @* begin
    if (read_latch) begin
        sel_code = dac_codes[frame_addr[1:0]*CODE_WIDTH +: CODE_WIDTH];
    end else begin
        sel_code = input_codes[frame_addr[1:0]*CODE_WIDTH +: CODE_WIDTH];
    end
    rd_data = 16'h0000;
    if (frame_addr == `QDCC_ADDR_CONTROL) begin
        rd_data = control_command;
    end else if (rd_known) begin
        rd_data[`QDCC_CODE_HI:`QDCC_CODE_LO] = sel_code;
    end
end

// the word is caught when the read frame ends and goes out on the
// next frame, so a gpio level is the one seen at the read command
always @(posedge clock) begin
    if (int_rst) begin
        tx_word <= 24'h000000;
    end else if (frame_valid && frame_read) begin
        tx_word <= {4'h0, frame_addr, rd_data};
    end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
// sleep touches only the analog side; the serial path is untouched
assign group_a_sleep = sleep_a;
assign group_b_sleep = sleep_b;
assign chan_gain_x4 = gain_x4;
assign gpio_out = 2'h0;
assign gpio_oe = ~gpio_release;

endmodule
